// file: rtl/eilu_pkg.sv
// Purpose: Shared constants and carriers for the encoder index latch unit
// Assumes: Register addresses are word indices on the serial register port
// Notes:   Config struct field order matches its bit order 10..0
package eilu_pkg;

  // Register addresses
  localparam logic [6:0] ADDR_RAMP_STATUS  = 7'h35;
  localparam logic [6:0] ADDR_RAMP_CAPTURE = 7'h36;
  localparam logic [6:0] ADDR_ENC_CONFIG   = 7'h38;
  localparam logic [6:0] ADDR_ENC_COUNT    = 7'h39;
  localparam logic [6:0] ADDR_ENC_CONST    = 7'h3a;
  localparam logic [6:0] ADDR_ENC_STATUS   = 7'h3b;
  localparam logic [6:0] ADDR_ENC_LATCH    = 7'h3c;

  // Field positions and config width
  localparam int STAT_STOP_L    = 0;
  localparam int STAT_STOP_R    = 1;
  localparam int STAT_LATCH_L   = 2;
  localparam int ENC_ST_NEVENT  = 0;
  localparam int CFG_ONCE_BIT   = 5;
  localparam int CFG_WIDTH      = 11;

  // Reset values
  localparam logic [10:0] CFG_RESET   = 11'h000;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] CONST_RESET = 32'h0001_0000;

  // Fraction divisors
  localparam logic [16:0] DIV_BINARY  = 17'h10000;
  localparam logic [16:0] DIV_DECIMAL = 17'h02710;

  // Index sensitivity codes
  localparam logic [1:0] SENS_LEVEL = 2'h0;
  localparam logic [1:0] SENS_RISE  = 2'h1;
  localparam logic [1:0] SENS_FALL  = 2'h2;
  localparam logic [1:0] SENS_BOTH  = 2'h3;

  typedef struct packed {
    logic       sel_decimal;
    logic       latch_ramp;
    logic       clear_count;
    logic [1:0] sens;
    logic       once;
    logic       cont;
    logic       index_skip_quadrature_gate;
    logic       pol_n;
    logic       pol_b;
    logic       pol_a;
  } eilu_cfg_s;

  typedef struct packed {
    logic        wr;
    logic [6:0]  addr;
    logic [31:0] wdata;
  } eilu_req_s;

  typedef struct packed {
    logic stop_r;
    logic stop_l;
    logic n;
    logic b;
    logic a;
  } eilu_pins_s;

endpackage

// file: rtl/eilu_sync_decode.sv
// Purpose: Pin synchroniser and quadrature step decoder
// Assumes: Pins are asynchronous to clk
// Notes:   A pin change counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module eilu_sync_decode
  import eilu_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Raw pins
  input  wire eilu_pins_s pins_raw,
  // Clean pins and steps
  output var  eilu_pins_s pins,
  output var  logic       step,
  output var  logic       dir_up
);

  eilu_pins_s s1;
  eilu_pins_s s2;
  eilu_pins_s s3;
  eilu_pins_s next_pins;
  logic       next_step;
  logic       next_dir_up;

  always_comb begin
    next_pins = pins;
    for (int i = 0; i < 5; i++) begin
      if (s2[i] == s3[i]) begin
        next_pins[i] = s3[i];
      end
    end
    next_step   = (next_pins.a ^ pins.a) ^ (next_pins.b ^ pins.b);
    next_dir_up = pins.a ^ next_pins.b;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1     <= '0;
      s2     <= '0;
      s3     <= '0;
      pins   <= '0;
      step   <= 1'b0;
      dir_up <= 1'b0;
    end else begin
      s1     <= pins_raw;
      s2     <= s1;
      s3     <= s2;
      pins   <= next_pins;
      step   <= next_step;
      dir_up <= next_dir_up;
    end
  end

endmodule // eilu_sync_decode
`default_nettype wire

// file: rtl/eilu_core.sv
// Purpose: Encoder counter, index event qualifier and position latches
// Assumes: Ramp position and switch latch pulse come from logic on clk
// Notes:   Read data follows the address with one cycle of latency
`timescale 1ns/1ps
`default_nettype none
module eilu_core
  import eilu_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Encoder and switch pins
  input  wire eilu_pins_s  pins_raw,
  // Ramp side
  input  wire logic [31:0] ramp_actual_position,
  input  wire logic        switch_latch_l,
  // Register port
  input  wire eilu_req_s   req,
  output var  logic [31:0] rdata
);

  eilu_pins_s  pins;
  logic        step;
  logic        dir_up;
  eilu_cfg_s   cfg;
  eilu_cfg_s   next_cfg;
  logic [31:0] enc_count;
  logic [31:0] next_enc_count;
  logic [15:0] frac_acc;
  logic [15:0] next_frac_acc;
  logic [31:0] enc_const;
  logic [31:0] next_enc_const;
  logic [31:0] enc_latch;
  logic [31:0] next_enc_latch;
  logic [31:0] ramp_capture;
  logic [31:0] next_ramp_capture;
  logic        n_event_flag;
  logic        next_n_event_flag;
  logic        latch_l_flag;
  logic        next_latch_l_flag;
  logic        once_armed;
  logic        next_once_armed;
  logic        n_act_prev;
  logic [31:0] next_rdata;
  logic        n_act;
  logic        n_evt;
  logic        do_latch;
  logic [47:0] accum;

  eilu_sync_decode u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pins_raw (pins_raw),
    .pins     (pins),
    .step     (step),
    .dir_up   (dir_up)
  );

  // Returns new fraction and signed count delta for one step
  function automatic logic [47:0] enc_accum(input logic [15:0] acc,
                                            input logic [31:0] k,
                                            input logic        up,
                                            input logic        dec);
    logic [17:0] sum;
    logic [17:0] div;
    logic        carry;
    logic [31:0] whole;
    div   = {1'b0, (dec ? DIV_DECIMAL : DIV_BINARY)};
    carry = 1'b0;
    if (up) begin
      sum = {2'b00, acc} + {2'b00, k[15:0]};
      if (sum >= div) begin
        sum   = sum - div;
        carry = 1'b1;
      end
    end else begin
      sum = {2'b00, acc} - {2'b00, k[15:0]};
      if (sum[17]) begin
        sum   = sum + div;
        carry = 1'b1;
      end
    end
    whole = {{16{k[31]}}, k[31:16]} + {31'h0, carry};
    return {sum[15:0], (up ? whole : 32'h0 - whole)};
  endfunction

  always_comb begin
    next_cfg          = cfg;
    next_enc_count    = enc_count;
    next_frac_acc     = frac_acc;
    next_enc_const    = enc_const;
    next_enc_latch    = enc_latch;
    next_ramp_capture = ramp_capture;
    next_n_event_flag = n_event_flag;
    next_latch_l_flag = latch_l_flag;
    next_once_armed   = once_armed;
    n_act = (pins.n == cfg.pol_n) &&
            (cfg.index_skip_quadrature_gate ||
             ((pins.a == cfg.pol_a) && (pins.b == cfg.pol_b)));
    case (cfg.sens)
      SENS_LEVEL: n_evt = n_act;
      SENS_RISE:  n_evt = n_act && !n_act_prev;
      SENS_FALL:  n_evt = !n_act && n_act_prev;
      default:    n_evt = n_act ^ n_act_prev;
    endcase
    do_latch = n_evt && (cfg.cont || once_armed);
    accum = enc_accum(frac_acc, enc_const, dir_up, cfg.sel_decimal);
    if (step) begin
      next_frac_acc  = accum[47:32];
      next_enc_count = enc_count + accum[31:0];
    end
    if (do_latch) begin
      next_enc_latch = enc_count;
      next_once_armed = 1'b0;
      if (cfg.clear_count) begin
        next_enc_count = COUNT_RESET;
        next_frac_acc  = 16'h0000;
      end
      if (cfg.latch_ramp) begin
        next_ramp_capture = ramp_actual_position;
      end
    end
    if (switch_latch_l) begin
      next_ramp_capture = ramp_actual_position;
      next_enc_latch    = enc_count;
    end
    if (req.wr) begin
      case (req.addr)
        ADDR_ENC_CONFIG: begin
          next_cfg        = eilu_cfg_s'(req.wdata[CFG_WIDTH-1:0]);
          next_once_armed = req.wdata[CFG_ONCE_BIT];
        end
        ADDR_ENC_COUNT: begin
          next_enc_count = req.wdata;
          next_frac_acc  = 16'h0000;
        end
        ADDR_ENC_CONST:  next_enc_const = req.wdata;
        ADDR_ENC_STATUS: begin
          if (req.wdata[ENC_ST_NEVENT]) begin
            next_n_event_flag = 1'b0;
          end
        end
        ADDR_RAMP_STATUS: begin
          if (req.wdata[STAT_LATCH_L]) begin
            next_latch_l_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (n_evt) begin
      next_n_event_flag = 1'b1;
    end
    if (switch_latch_l) begin
      next_latch_l_flag = 1'b1;
    end
    case (req.addr)
      ADDR_RAMP_STATUS:  next_rdata = {29'h0, latch_l_flag, pins.stop_r, pins.stop_l};
      ADDR_RAMP_CAPTURE: next_rdata = ramp_capture;
      ADDR_ENC_CONFIG:   next_rdata = {21'h0, cfg};
      ADDR_ENC_COUNT:    next_rdata = enc_count;
      ADDR_ENC_CONST:    next_rdata = enc_const;
      ADDR_ENC_STATUS:   next_rdata = {31'h0, n_event_flag};
      ADDR_ENC_LATCH:    next_rdata = enc_latch;
      default:           next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg          <= eilu_cfg_s'(CFG_RESET);
      enc_count    <= COUNT_RESET;
      frac_acc     <= 16'h0000;
      enc_const    <= CONST_RESET;
      enc_latch    <= COUNT_RESET;
      ramp_capture <= COUNT_RESET;
      n_event_flag <= 1'b0;
      latch_l_flag <= 1'b0;
      once_armed   <= 1'b0;
      n_act_prev   <= 1'b0;
      rdata        <= 32'h0;
    end else begin
      cfg          <= next_cfg;
      enc_count    <= next_enc_count;
      frac_acc     <= next_frac_acc;
      enc_const    <= next_enc_const;
      enc_latch    <= next_enc_latch;
      ramp_capture <= next_ramp_capture;
      n_event_flag <= next_n_event_flag;
      latch_l_flag <= next_latch_l_flag;
      once_armed   <= next_once_armed;
      n_act_prev   <= n_act;
      rdata        <= next_rdata;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_rise;
    !n_act ##1 n_act;
  endsequence

  sequence s_count_write;
    req.wr && (req.addr == ADDR_ENC_COUNT);
  endsequence

  a_left_flag_set:
    assert property (switch_latch_l |=> latch_l_flag)
      else $error("left latch flag not set");
  a_left_flag_clr:
    assert property (req.wr && req.addr == ADDR_RAMP_STATUS && req.wdata[STAT_LATCH_L]
                     && !switch_latch_l |=> !latch_l_flag)
      else $error("left latch flag not cleared");
  a_switch_state_read:
    assert property (req.addr == ADDR_RAMP_STATUS
                     |=> rdata[1:0] == $past({pins.stop_r, pins.stop_l}))
      else $error("switch state misreported");
  a_switch_capture:
    assert property (switch_latch_l |=> ramp_capture == $past(ramp_actual_position))
      else $error("ramp position not captured");
  a_decimal_range:
    assert property (step && cfg.sel_decimal && frac_acc < DIV_DECIMAL[15:0]
                     && enc_const[15:0] < DIV_DECIMAL[15:0] && !req.wr
                     |=> frac_acc < DIV_DECIMAL[15:0])
      else $error("decimal fraction out of range");
  a_index_ramp:
    assert property (do_latch && cfg.latch_ramp && !switch_latch_l
                     |=> ramp_capture == $past(ramp_actual_position))
      else $error("ramp not captured on index");
  a_index_clear:
    assert property (do_latch && cfg.clear_count && !(req.wr && req.addr == ADDR_ENC_COUNT)
                     |=> enc_count == 32'h0 && enc_latch == $past(enc_count))
      else $error("index clear failed");
  a_rise_event:
    assert property (s_rise |-> (cfg.sens != SENS_RISE || n_evt))
      else $error("rising index event missed");
  a_once_disarm:
    assert property (once_armed && do_latch && !req.wr |=> !once_armed)
      else $error("one-shot not disarmed");
  a_count_write:
    assert property (s_count_write |=> enc_count == $past(req.wdata))
      else $error("count write lost");
  a_index_flag:
    assert property (n_evt |=> n_event_flag)
      else $error("index flag not set");

endmodule // eilu_core
`default_nettype wire

// file: bench/eilu_enc_model.sv
// Purpose: Encoder, index and switch pin model
// Assumes: Calls arrive at the falling clock edge
// Notes:   Pins hold their last driven level
`timescale 1ns/1ps
`default_nettype none
module eilu_enc_model
  import eilu_pkg::*;
(
  // Encoder and switch pins
  output var eilu_pins_s pins
);
  logic [1:0] ph;
  initial begin
    pins = '0;
    ph   = 2'h0;
  end
  // One quadrature step, B leads A going up
  task automatic step(input logic up);
    ph     = up ? ph + 2'h1 : ph - 2'h1;
    pins.a = ph[1];
    pins.b = ph[1] ^ ph[0];
  endtask
  task automatic set_n(input logic v);
    pins.n = v;
  endtask
  task automatic set_sw(input logic l, input logic r);
    pins.stop_l = l;
    pins.stop_r = r;
  endtask
endmodule // eilu_enc_model
`default_nettype wire

// file: bench/tb.sv
// Purpose: Self-checking bench for the encoder index latch unit
// Assumes: Partner model drives encoder and switch pins
// Notes:   Every register read is compared with an integer model
`timescale 1ns/1ps
`default_nettype none
module tb
  import eilu_pkg::*;
;
  logic        clk;
  logic        sys_rst;
  eilu_pins_s  pins;
  logic [31:0] ramp;
  logic        sw_latch;
  eilu_req_s   req;
  logic [31:0] rdata;
  int          n_fail;
  int          comparisons;
  int          m_frac;
  logic [31:0] rnd;
  logic [31:0] m_cnt, m_const, m_latch, m_cap;
  logic [10:0] m_cfg;
  logic        m_latl, m_nflag, m_armed;

  eilu_core u_dut (.clk(clk), .sys_rst(sys_rst), .pins_raw(pins),
    .ramp_actual_position(ramp), .switch_latch_l(sw_latch), .req(req), .rdata(rdata));
  eilu_enc_model u_enc (.pins(pins));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [31:0] m_reg(input logic [6:0] a);
    case (a)
      ADDR_RAMP_STATUS:  return {29'h0, m_latl, pins.stop_r, pins.stop_l};
      ADDR_RAMP_CAPTURE: return m_cap;
      ADDR_ENC_CONFIG:   return {21'h0, m_cfg};
      ADDR_ENC_COUNT:    return m_cnt;
      ADDR_ENC_CONST:    return m_const;
      ADDR_ENC_STATUS:   return {31'h0, m_nflag};
      ADDR_ENC_LATCH:    return m_latch;
      default:           return 32'h0;
    endcase
  endfunction

  task automatic stop_test();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    req = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
    @(negedge clk);
    case (a)
      ADDR_ENC_CONFIG: begin
        m_cfg   = d[10:0];
        m_armed = d[5];
      end
      ADDR_ENC_COUNT: begin
        m_cnt  = d;
        m_frac = 0;
      end
      ADDR_ENC_CONST:   m_const = d;
      ADDR_RAMP_STATUS: m_latl = m_latl & ~d[2];
      ADDR_ENC_STATUS:  m_nflag = m_nflag & ~d[0];
      default: ;
    endcase
  endtask

  task automatic chk(input logic [6:0] a);
    logic [31:0] e;
    e = m_reg(a);
    req.addr = a;
    @(negedge clk);
    comparisons++;
    if (rdata !== e) begin
      n_fail++;
      $display("mismatch reg %h expected %h seen %h", a, e, rdata);
    end
  endtask

  task automatic chk_all();
    for (int i = 0; i < 8; i++) begin
      chk(ADDR_RAMP_STATUS + 7'(i));
    end
  endtask

  task automatic step(input logic up);
    logic [31:0] k;
    int          dv;
    k  = m_const;
    dv = m_cfg[10] ? 10000 : 65536;
    u_enc.step(up);
    idle(8);
    if (up) begin
      m_frac += k[15:0];
      m_cnt += {{16{k[31]}}, k[31:16]};
      if (m_frac >= dv) begin
        m_frac -= dv;
        m_cnt += 32'h1;
      end
    end else begin
      m_frac -= k[15:0];
      m_cnt -= {{16{k[31]}}, k[31:16]};
      if (m_frac < 0) begin
        m_frac += dv;
        m_cnt -= 32'h1;
      end
    end
  endtask

  task automatic m_index();
    m_nflag = 1'b1;
    if (m_cfg[4] || m_armed) begin
      m_latch = m_cnt;
      if (m_cfg[9]) m_cap = ramp;
      if (m_cfg[8]) begin
        m_cnt  = 32'h0;
        m_frac = 0;
      end
      m_armed = 1'b0;
    end
  endtask

  task automatic pulse(input logic ok, input int k);
    logic [1:0] s;
    s = m_cfg[7:6];
    u_enc.set_n(m_cfg[2]);
    idle(8);
    if (ok && s[0]) m_index();
    repeat (k) step(1'b1);
    u_enc.set_n(~m_cfg[2]);
    idle(8);
    if (ok && s != SENS_RISE) m_index();
  endtask

  task automatic scen(input logic [10:0] c, input logic ok, input int k);
    wr(ADDR_ENC_CONFIG, {28'h0, 1'b1, c[2], 2'h0});
    u_enc.set_n(~c[2]);
    idle(8);
    wr(ADDR_ENC_CONFIG, {21'h0, c});
    rnd = lfsr(rnd);
    wr(ADDR_ENC_COUNT, rnd);
    wr(ADDR_ENC_STATUS, 32'h1);
    rnd  = lfsr(rnd);
    ramp = rnd;
    pulse(ok, k);
    chk_all();
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test();
  end

  initial begin
    n_fail = 0;
    comparisons = 0;
    rnd = 32'h6;
    req = '0;
    ramp = 32'h0;
    sw_latch = 1'b0;
    sys_rst = 1'b1;
    m_cfg = '0;
    m_cnt = 32'h0;
    m_const = 32'h0001_0000;
    m_latch = 32'h0;
    m_cap = 32'h0;
    m_frac = 0;
    {m_latl, m_nflag, m_armed} = 3'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    idle(4);
    m_nflag = (pins.n == m_cfg[2]) && (pins.a == m_cfg[0]) && (pins.b == m_cfg[1]);
    chk_all();
    wr(ADDR_RAMP_CAPTURE, rnd);
    wr(ADDR_ENC_LATCH, rnd);
    wr(ADDR_ENC_CONFIG, {rnd[31:11], 11'h40c});
    chk_all();
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_ENC_CONFIG, i == 1 ? 32'h400 : 32'h0);
      wr(ADDR_ENC_CONST, i == 0 ? 32'h8000 : (i == 1 ? 32'h1_1388 : 32'hfffe_c000));
      rnd = lfsr(rnd);
      wr(ADDR_ENC_COUNT, rnd);
      repeat (3) step(1'b1);
      repeat (5) step(1'b0);
      chk(ADDR_ENC_COUNT);
    end
    wr(ADDR_ENC_CONST, 32'h0001_0000);
    for (int i = 0; i < 8; i++) begin
      scen({2'h0, i[2:1] != 2'h0, i[2:1], 2'h1, 1'b1, i[0], 2'h0}, 1'b1, 3);
    end
    scen(11'h06c, 1'b1, 0);
    wr(ADDR_ENC_COUNT, lfsr(rnd));
    pulse(1'b1, 0);
    chk_all();
    scen(11'h25c, 1'b1, 2);
    scen(11'h05c, 1'b1, 2);
    scen(11'h054 | {9'h0, ~pins.b, ~pins.a}, 1'b0, 0);
    scen(11'h054 | {9'h0, pins.b, pins.a}, 1'b1, 0);
    u_enc.set_sw(1'b1, 1'b0);
    idle(8);
    chk_all();
    u_enc.set_sw(1'b0, 1'b1);
    rnd = lfsr(rnd);
    ramp = rnd;
    sw_latch = 1'b1;
    idle(1);
    sw_latch = 1'b0;
    m_cap = ramp;
    m_latch = m_cnt;
    m_latl = 1'b1;
    idle(8);
    chk_all();
    wr(ADDR_RAMP_STATUS, 32'h4);
    chk_all();
    stop_test();
  end
endmodule // tb
`default_nettype wire
